// ===== hdl/psq_pkg.sv
/*
 * psq_pkg: constants, types and the data map of the program sequencer.
 * assumes a single 50 MHz system clock and an active-low chip reset.
 */
package psq_pkg;
  localparam int PSQ_PC_W = 11;
  localparam int PSQ_WORD_W = 14;
  localparam int PSQ_ROM_DEPTH = 2048;
  localparam int PSQ_STACK_DEPTH = 6;
  localparam int PSQ_RAM_DEPTH = 64;
  localparam logic [1:0] PSQ_PHASES_LAST = 2'h3;
  localparam logic [10:0] PSQ_VEC_RESET = 11'h000;
  localparam logic [10:0] PSQ_VEC_EXT = 11'h004;
  localparam logic [10:0] PSQ_VEC_TMR = 11'h008;
  localparam logic [10:0] PSQ_VEC_ADC = 11'h00C;
  localparam logic [2:0] PSQ_LAST_PAGE = 3'h7;
  localparam logic [6:0] PSQ_ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] PSQ_ADDR_MP = 7'h01;
  localparam logic [6:0] PSQ_ADDR_ACC = 7'h05;
  localparam logic [6:0] PSQ_ADDR_PCL = 7'h06;
  localparam logic [6:0] PSQ_ADDR_TABLE_POINTER = 7'h07;
  localparam logic [6:0] PSQ_ADDR_TABLE_HIGH_BYTE = 7'h08;
  localparam logic [6:0] PSQ_ADDR_STATUS = 7'h0A;
  localparam logic [6:0] PSQ_ADDR_INTERRUPT_CONTROL = 7'h0B;
  localparam logic [6:0] PSQ_ADDR_TMR = 7'h0D;
  localparam logic [6:0] PSQ_ADDR_TIMER_CONTROL = 7'h0E;
  localparam logic [6:0] PSQ_ADDR_PA = 7'h12;
  localparam logic [6:0] PSQ_ADDR_PAC = 7'h13;
  localparam logic [6:0] PSQ_ADDR_PB = 7'h14;
  localparam logic [6:0] PSQ_ADDR_PBC = 7'h15;
  localparam logic [6:0] PSQ_ADDR_PD = 7'h18;
  localparam logic [6:0] PSQ_ADDR_PDC = 7'h19;
  localparam logic [6:0] PSQ_ADDR_PWM = 7'h1A;
  localparam logic [6:0] PSQ_ADDR_ADC_RESULT_LOW = 7'h20;
  localparam logic [6:0] PSQ_ADDR_ADC_RESULT_HIGH = 7'h21;
  localparam logic [6:0] PSQ_ADDR_ADC_CONTROL = 7'h22;
  localparam logic [6:0] PSQ_ADDR_ADC_CLOCK_SETTING = 7'h23;
  localparam logic [6:0] PSQ_ADDR_RAM_LO = 7'h40;
  localparam logic [7:0] PSQ_MP_BIT7 = 8'h80;
  localparam logic [7:0] PSQ_RST_BYTE = 8'h00;
  localparam logic [2:0] PSQ_SP_EMPTY = 3'h0;
  localparam logic [2:0] PSQ_SP_FULL = 3'h6;

  // operation class decoded by the external instruction decoder
  typedef enum logic [3:0] {
    PSQ_OP_NONE = 4'h0,
    PSQ_OP_JUMP = 4'h1,
    PSQ_OP_CALL = 4'h2,
    PSQ_OP_RET = 4'h3,
    PSQ_OP_RETURN_ENABLE_INTERRUPTS = 4'h4,
    PSQ_OP_SKIP = 4'h5,
    PSQ_OP_TRD_CUR = 4'h6,
    PSQ_OP_TRD_LAST = 4'h7,
    PSQ_OP_MOV_TO_ACC = 4'h8,
    PSQ_OP_MOV_FROM_ACC = 4'h9,
    PSQ_OP_RMW = 4'hA
  } psq_op_type;

  typedef enum logic [1:0] {
    PSQ_EXEC = 2'b00,
    PSQ_DUMMY = 2'b01,
    PSQ_TABLE = 2'b10
  } psq_state_type;

  typedef struct packed {
    psq_op_type op;
    logic [10:0] target;
    logic [6:0] addr;
    logic skip_true;
    logic [7:0] alu_result;
  } psq_cmd_type;

  typedef struct packed {
    logic ext;
    logic tmr;
    logic adc;
  } psq_irq_type;
endpackage

// ===== hdl/psq_sequencer.sv
/*
 * psq_sequencer: four-phase instruction cycle, fetch/execute pipeline, program counter,
 * return stack, table reads and the data memory map with indirect access.
 * assumes an external decoder drives cmd_in once per instruction cycle (valid at phase 3)
 * and an interrupt controller raises pending requests already gated by enables.
 */
`timescale 1ns/1ps
module psq_sequencer
  import psq_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire psq_cmd_type cmd_in,
  input wire psq_irq_type irq_pend_in,
  input wire logic rom_we_in,
  input wire logic [10:0] rom_waddr_in,
  input wire logic [13:0] rom_wdata_in,
  output logic [1:0] phase_out,
  output logic cycle_end_out,
  output logic [13:0] instr_out,
  output logic instr_valid_out,
  output logic [10:0] pc_out,
  output psq_irq_type irq_ack_out,
  output logic [7:0] rd_data_out,
  output logic [7:0] acc_out,
  output logic stack_full_out
);
  logic [1:0] phase_q, phase_d;
  logic [10:0] pc_q, pc_d;
  psq_state_type state_q, state_d;
  logic [13:0] ir_q, ir_d;
  logic [10:0] stack_q [PSQ_STACK_DEPTH];
  logic [2:0] sp_q, sp_d;
  logic [2:0] top_q, top_d;
  logic [2:0] wptr_q, wptr_d;
  logic [7:0] mp_q, mp_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] table_pointer_q, table_pointer_d;
  logic [5:0] table_high_byte_q, table_high_byte_d;
  logic [7:0] ram_q [PSQ_RAM_DEPTH];
  logic [13:0] rom [PSQ_ROM_DEPTH];
  logic [10:0] tbl_addr_q, tbl_addr_d;
  logic [6:0] tbl_dst_q, tbl_dst_d;
  logic [7:0] rd_q, rd_d;
  psq_irq_type ack_q, ack_d;

  logic last_phase;
  logic [6:0] eff_addr;
  logic eff_null;
  logic [7:0] rd_mux;
  logic wr_en;
  logic [7:0] wr_data;
  logic [6:0] wr_addr;
  logic push;
  logic pop;
  logic irq_take;
  logic [10:0] vector;
  logic [13:0] rom_rd;

  assign last_phase = (phase_q == PSQ_PHASES_LAST);
  assign rom_rd = (state_q == PSQ_TABLE) ? rom[tbl_addr_q] : rom[pc_q];

  always_ff @(posedge clk_in) begin
    if (rom_we_in) begin
      rom[rom_waddr_in] <= rom_wdata_in;
    end
  end

  always_comb begin
    eff_addr = cmd_in.addr;
    eff_null = 1'b0;
    if (cmd_in.addr == PSQ_ADDR_INDIRECT) begin
      eff_addr = mp_q[6:0];
      eff_null = (mp_q[6:0] == PSQ_ADDR_INDIRECT);
    end
  end

  always_comb begin
    rd_mux = PSQ_RST_BYTE;
    if (!eff_null) begin
      if (eff_addr >= PSQ_ADDR_RAM_LO) begin
        rd_mux = ram_q[eff_addr[5:0]];
      end else begin
        case (eff_addr)
          PSQ_ADDR_MP: rd_mux = mp_q | PSQ_MP_BIT7;
          PSQ_ADDR_ACC: rd_mux = acc_q;
          PSQ_ADDR_PCL: rd_mux = pc_q[7:0];
          PSQ_ADDR_TABLE_POINTER: rd_mux = table_pointer_q;
          PSQ_ADDR_TABLE_HIGH_BYTE: rd_mux = {2'b00, table_high_byte_q};
          default: rd_mux = PSQ_RST_BYTE;
        endcase
      end
    end
  end

  always_comb begin
    ack_d = '0;
    vector = PSQ_VEC_RESET;
    if (irq_pend_in.ext) begin
      ack_d.ext = 1'b1;
      vector = PSQ_VEC_EXT;
    end else if (irq_pend_in.tmr) begin
      ack_d.tmr = 1'b1;
      vector = PSQ_VEC_TMR;
    end else if (irq_pend_in.adc) begin
      ack_d.adc = 1'b1;
      vector = PSQ_VEC_ADC;
    end
  end

  always_comb begin
    phase_d = phase_q + 2'h1;
    pc_d = pc_q;
    state_d = state_q;
    ir_d = ir_q;
    sp_d = sp_q;
    top_d = top_q;
    wptr_d = wptr_q;
    mp_d = mp_q;
    acc_d = acc_q;
    table_pointer_d = table_pointer_q;
    table_high_byte_d = table_high_byte_q;
    tbl_addr_d = tbl_addr_q;
    tbl_dst_d = tbl_dst_q;
    rd_d = rd_q;
    wr_en = 1'b0;
    wr_data = cmd_in.alu_result;
    wr_addr = eff_addr;
    push = 1'b0;
    pop = 1'b0;
    irq_take = 1'b0;
    if (last_phase) begin
      rd_d = rd_mux;
      ir_d = rom_rd;
      pc_d = pc_q + 11'h001;
      state_d = PSQ_EXEC;
      irq_take = (state_q == PSQ_EXEC) && (irq_pend_in != '0) && (sp_q != PSQ_SP_FULL)
        && (cmd_in.op == PSQ_OP_NONE);
      if (state_q == PSQ_TABLE) begin
        table_high_byte_d = rom_rd[13:8];
        wr_en = !(tbl_dst_q == PSQ_ADDR_INDIRECT && mp_q[6:0] == PSQ_ADDR_INDIRECT);
        wr_addr = (tbl_dst_q == PSQ_ADDR_INDIRECT) ? mp_q[6:0] : tbl_dst_q;
        wr_data = rom_rd[7:0];
        ir_d = ir_q; // next instruction was fetched with the read command
        pc_d = pc_q;
        state_d = PSQ_EXEC;
      end else if (state_q == PSQ_DUMMY) begin
        // dummy cycle only fetches the new target; no command is taken
        wr_en = 1'b0;
      end else if (irq_take) begin
        push = 1'b1;
        pc_d = vector;
        state_d = PSQ_DUMMY;
      end else begin
        case (cmd_in.op)
          PSQ_OP_JUMP: begin
            pc_d = cmd_in.target;
            state_d = PSQ_DUMMY;
          end
          PSQ_OP_CALL: begin
            push = 1'b1;
            pc_d = cmd_in.target;
            state_d = PSQ_DUMMY;
          end
          PSQ_OP_RET, PSQ_OP_RETURN_ENABLE_INTERRUPTS: begin
            pop = 1'b1;
            pc_d = stack_q[top_q];
            state_d = PSQ_DUMMY;
          end
          PSQ_OP_SKIP: begin
            if (cmd_in.skip_true) begin
              state_d = PSQ_DUMMY;
            end
          end
          PSQ_OP_TRD_CUR, PSQ_OP_TRD_LAST: begin
            tbl_addr_d = {(cmd_in.op == PSQ_OP_TRD_LAST) ? PSQ_LAST_PAGE : pc_q[10:8], table_pointer_q};
            tbl_dst_d = cmd_in.addr;
            state_d = PSQ_TABLE;
          end
          PSQ_OP_MOV_TO_ACC: begin
            acc_d = rd_mux;
          end
          PSQ_OP_MOV_FROM_ACC: begin
            wr_en = !eff_null;
            wr_data = acc_q;
          end
          PSQ_OP_RMW: begin
            wr_en = !eff_null;
          end
          default: begin
            pc_d = pc_q + 11'h001;
          end
        endcase
      end
      if (wr_en) begin
        case (wr_addr)
          PSQ_ADDR_MP: mp_d = {1'b0, wr_data[6:0]};
          PSQ_ADDR_ACC: acc_d = wr_data;
          PSQ_ADDR_TABLE_POINTER: table_pointer_d = wr_data;
          PSQ_ADDR_PCL: begin
            pc_d = {pc_q[10:8], wr_data};
            state_d = PSQ_DUMMY;
          end
          default: ;
        endcase
      end
      if (push) begin
        top_d = wptr_q;
        wptr_d = (wptr_q == PSQ_SP_FULL - 3'h1) ? 3'h0 : wptr_q + 3'h1;
        if (sp_q != PSQ_SP_FULL) begin
          sp_d = sp_q + 3'h1;
        end
      end else if (pop && sp_q != PSQ_SP_EMPTY) begin
        sp_d = sp_q - 3'h1;
        wptr_d = top_q;
        top_d = (top_q == 3'h0) ? PSQ_SP_FULL - 3'h1 : top_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      stack_q[wptr_q] <= pc_q;
    end
    if (wr_en && wr_addr >= PSQ_ADDR_RAM_LO) begin
      ram_q[wr_addr[5:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= 2'h0;
      pc_q <= PSQ_VEC_RESET;
      state_q <= PSQ_EXEC;
      ir_q <= 14'h0000;
      sp_q <= PSQ_SP_EMPTY;
      top_q <= 3'h0;
      wptr_q <= 3'h0;
      mp_q <= PSQ_RST_BYTE;
      acc_q <= PSQ_RST_BYTE;
      table_pointer_q <= PSQ_RST_BYTE;
      table_high_byte_q <= 6'h00;
      tbl_addr_q <= 11'h000;
      tbl_dst_q <= 7'h00;
      rd_q <= PSQ_RST_BYTE;
      ack_q <= '0;
    end else begin
      phase_q <= phase_d;
      pc_q <= pc_d;
      state_q <= state_d;
      ir_q <= ir_d;
      sp_q <= sp_d;
      top_q <= top_d;
      wptr_q <= wptr_d;
      mp_q <= mp_d;
      acc_q <= acc_d;
      table_pointer_q <= table_pointer_d;
      table_high_byte_q <= table_high_byte_d;
      tbl_addr_q <= tbl_addr_d;
      tbl_dst_q <= tbl_dst_d;
      rd_q <= rd_d;
      ack_q <= irq_take ? ack_d : '0;
    end
  end

  assign phase_out = phase_q;
  assign cycle_end_out = last_phase;
  assign instr_out = ir_q;
  assign instr_valid_out = (state_q == PSQ_EXEC);
  assign pc_out = pc_q;
  assign irq_ack_out = ack_q;
  assign rd_data_out = rd_q;
  assign acc_out = acc_q;
  assign stack_full_out = (sp_q == PSQ_SP_FULL);

  a_phase_period: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    last_phase |=> !last_phase [*3] ##1 last_phase)
    else $error("instruction cycle not four clocks");
  a_pc_increment: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC && cmd_in.op == PSQ_OP_NONE && !irq_take)
    |=> pc_q == $past(pc_q) + 11'h001)
    else $error("pc did not increment");
  a_jump_dummy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC && !irq_take && cmd_in.op == PSQ_OP_JUMP)
    |=> state_q == PSQ_DUMMY && pc_q == $past(cmd_in.target))
    else $error("jump did not load target with dummy cycle");
  a_skip_dummy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC && !irq_take && cmd_in.op == PSQ_OP_SKIP
     && cmd_in.skip_true) |=> state_q == PSQ_DUMMY ##4 pc_q == $past(pc_q, 5) + 11'h002)
    else $error("skip did not reach pc plus two");
  a_irq_full: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    stack_full_out |-> !irq_take)
    else $error("interrupt taken with full stack");
  a_irq_vector: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (irq_take && irq_pend_in.ext) |=> pc_q == PSQ_VEC_EXT && irq_ack_out.ext)
    else $error("external vector wrong");
  a_irq_prio: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (irq_take && !irq_pend_in.ext && irq_pend_in.tmr) |=> pc_q == PSQ_VEC_TMR)
    else $error("timer priority wrong");
  a_mp_bit7: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !mp_q[7])
    else $error("memory pointer stored bit 7");
  a_table_two: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC && cmd_in.addr != PSQ_ADDR_PCL
     && (cmd_in.op == PSQ_OP_TRD_CUR || cmd_in.op == PSQ_OP_TRD_LAST))
    |=> state_q == PSQ_TABLE ##4 state_q == PSQ_EXEC)
    else $error("table read not two cycles");
  a_pcl_jump: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && wr_en && wr_addr == PSQ_ADDR_PCL)
    |=> pc_q == {$past(pc_q[10:8]), $past(wr_data)} && state_q == PSQ_DUMMY)
    else $error("pc low byte write not a page jump");
  a_ret_top: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC
     && (cmd_in.op == PSQ_OP_RET || cmd_in.op == PSQ_OP_RETURN_ENABLE_INTERRUPTS))
    |=> pc_q == $past(stack_q[top_q]))
    else $error("return did not load top stack entry");
  a_last_page: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC && cmd_in.op == PSQ_OP_TRD_LAST)
    |=> tbl_addr_q == {PSQ_LAST_PAGE, $past(table_pointer_q)})
    else $error("last page table address wrong");
  a_table_high_byte_load: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_TABLE) |=> table_high_byte_q == $past(rom_rd[13:8]))
    else $error("table high not loaded");
  a_reset_pc: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) |-> pc_q == PSQ_VEC_RESET && sp_q == PSQ_SP_EMPTY)
    else $error("reset state wrong");
  a_null_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (last_phase && state_q == PSQ_EXEC && eff_null) |-> !wr_en)
    else $error("write through null pointer");
  a_sp_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sp_q <= PSQ_SP_FULL)
    else $error("stack depth exceeded");
endmodule

// ===== sim/tb.sv
/*
 * tb: self-checking bench for psq_sequencer, issuing decoded ops once per instruction cycle.
 * assumes the program memory load port may be used while the core runs freely.
 */
`timescale 1ns/1ps
module tb;
  import psq_pkg::*;
  logic clk_in;
  logic reset_n_in;
  psq_cmd_type cmd_in;
  psq_irq_type irq_pend_in;
  logic rom_we_in;
  logic [10:0] rom_waddr_in;
  logic [13:0] rom_wdata_in;
  logic [1:0] phase_out;
  logic cycle_end_out;
  logic [13:0] instr_out;
  logic instr_valid_out;
  logic [10:0] pc_out;
  psq_irq_type irq_ack_out;
  logic [7:0] rd_data_out;
  logic [7:0] acc_out;
  logic stack_full_out;
  psq_irq_type irq_v;
  psq_irq_type ack_seen;
  logic [10:0] p0;
  logic [10:0] pi;
  logic [10:0] ret [7];
  logic [13:0] w;
  logic [6:0] rsv [4] = '{7'h02, 7'h09, 7'h24, 7'h3F};
  psq_irq_type pend [3] = '{3'b111, 3'b011, 3'b001};
  psq_irq_type acks [3] = '{3'b100, 3'b010, 3'b001};
  logic [10:0] vec [3] = '{PSQ_VEC_EXT, PSQ_VEC_TMR, PSQ_VEC_ADC};
  int miscompares;
  int comparisons;
  int n;
  int k;

  psq_sequencer dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd_in),
    .irq_pend_in(irq_pend_in), .rom_we_in(rom_we_in), .rom_waddr_in(rom_waddr_in),
    .rom_wdata_in(rom_wdata_in), .phase_out(phase_out), .cycle_end_out(cycle_end_out),
    .instr_out(instr_out), .instr_valid_out(instr_valid_out), .pc_out(pc_out),
    .irq_ack_out(irq_ack_out), .rd_data_out(rd_data_out), .acc_out(acc_out),
    .stack_full_out(stack_full_out));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // collects every acknowledge pulse since the last clear
  always @(posedge clk_in) ack_seen <= ack_seen | irq_ack_out;

  // program word derived from its address, unique per location
  function automatic logic [13:0] rw(input logic [10:0] a);
    return {a[10:8] ^ 3'h5, a[2:0], a[7:0] ^ 8'h3C};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    comparisons++;
    if (seen !== expected) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // stops at the edge that enters phase 3 of a real instruction cycle
  task automatic sync;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!(phase_out === 2'h2 && instr_valid_out === 1'b1) && n < 40);
    if (!(phase_out === 2'h2 && instr_valid_out === 1'b1)) miscompares++;
  endtask

  task automatic op(input psq_op_type o, input logic [10:0] t, input logic [6:0] a,
                    input logic sk, input logic [7:0] v);
    sync;
    p0 = pc_out;
    cmd_in <= psq_cmd_type'({o, t, a, sk, v});
    irq_pend_in <= irq_v;
    @(posedge clk_in);
    cmd_in <= '0;
    irq_pend_in <= '0;
    #1;
  endtask

  task automatic go(input psq_op_type o);
    op(o, 11'h000, 7'h00, 1'b0, 8'h00);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    op(PSQ_OP_RMW, 11'h000, a, 1'b0, v);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    op(PSQ_OP_MOV_TO_ACC, 11'h000, a, 1'b0, 8'h00);
    check(16'(acc_out), 16'(e));
    check(16'(rd_data_out), 16'(e));
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    wrap_up();
  end

  initial begin
    miscompares = 0;
    comparisons = 0;
    reset_n_in = 1'b0;
    cmd_in = '0;
    irq_pend_in = '0;
    irq_v = '0;
    ack_seen = '0;
    rom_we_in = 1'b0;
    rom_waddr_in = 11'h000;
    rom_wdata_in = 14'h0000;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < PSQ_ROM_DEPTH; i++) begin
      @(posedge clk_in);
      rom_we_in <= 1'b1;
      rom_waddr_in <= 11'(i);
      rom_wdata_in <= rw(11'(i));
    end
    @(posedge clk_in);
    rom_we_in <= 1'b0;
    reset_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    check(16'(pc_out), 16'h0000);
    check(16'(stack_full_out), 16'h0000);
    reset_n_in <= 1'b1;
    sync;
    @(posedge clk_in);
    #1;
    check(16'(instr_out), 16'(rw(11'h000)));
    check(16'(pc_out), 16'h0001);
    go(PSQ_OP_NONE);
    check(16'(instr_out), 16'(rw(p0)));
    check(16'(pc_out), 16'(p0 + 11'h001));
    k = 0;
    repeat (12) begin
      @(posedge clk_in);
      if (cycle_end_out === 1'b1) k++;
    end
    check(16'(k), 16'h0003);
    op(PSQ_OP_JUMP, 11'h5F0, 7'h00, 1'b0, 8'h00);
    check(16'(instr_valid_out), 16'h0000);
    sync;
    check(16'(instr_out), 16'(rw(11'h5F0)));
    check(16'(pc_out), 16'h05F1);
    op(PSQ_OP_SKIP, 11'h000, 7'h00, 1'b1, 8'h00);
    check(16'(instr_valid_out), 16'h0000);
    sync;
    check(16'(instr_out), 16'(rw(p0 + 11'h001)));
    check(16'(pc_out), 16'(p0 + 11'h002));
    go(PSQ_OP_SKIP);
    check(16'(instr_valid_out), 16'h0001);
    check(16'(instr_out), 16'(rw(p0)));
    wr(PSQ_ADDR_PCL, 8'h20);
    check(16'(instr_valid_out), 16'h0000);
    sync;
    check(16'(instr_out), 16'(rw({p0[10:8], 8'h20})));
    wr(PSQ_ADDR_TABLE_POINTER, 8'h9C);
    op(PSQ_OP_TRD_CUR, 11'h000, 7'h40, 1'b0, 8'h00);
    check(16'(instr_valid_out), 16'h0000);
    w = rw({p0[10:8], 8'h9C});
    rd(7'h40, w[7:0]);
    rd(PSQ_ADDR_TABLE_HIGH_BYTE, {2'b00, w[13:8]});
    wr(PSQ_ADDR_MP, 8'h41);
    go(PSQ_OP_TRD_LAST);
    w = rw({PSQ_LAST_PAGE, 8'h9C});
    rd(7'h41, w[7:0]);
    rd(PSQ_ADDR_TABLE_HIGH_BYTE, {2'b00, w[13:8]});
    wr(PSQ_ADDR_MP, 8'h45);
    rd(PSQ_ADDR_MP, 8'hC5);
    wr(PSQ_ADDR_INDIRECT, 8'h3C);
    rd(7'h45, 8'h3C);
    rd(PSQ_ADDR_INDIRECT, 8'h3C);
    wr(PSQ_ADDR_MP, 8'h80);
    rd(PSQ_ADDR_MP, 8'h80);
    wr(PSQ_ADDR_INDIRECT, 8'h77);
    rd(PSQ_ADDR_INDIRECT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(rsv[i], 8'h00);
    end
    wr(7'h7F, 8'hD2);
    rd(7'h7F, 8'hD2);
    op(PSQ_OP_MOV_FROM_ACC, 11'h000, 7'h40, 1'b0, 8'h00);
    rd(7'h40, 8'hD2);
    rd(PSQ_ADDR_ACC, 8'hD2);
    for (int i = 0; i < 3; i++) begin
      ack_seen = '0;
      irq_v = pend[i];
      go(PSQ_OP_NONE);
      irq_v = '0;
      pi = p0;
      sync;
      check(16'(ack_seen), 16'(acks[i]));
      check(16'(instr_out), 16'(rw(vec[i])));
      go(PSQ_OP_RETURN_ENABLE_INTERRUPTS);
      sync;
      check(16'(instr_out), 16'(rw(pi)));
    end
    for (int i = 0; i < 7; i++) begin
      op(PSQ_OP_CALL, 11'h200 + 11'(i * 32), 7'h00, 1'b0, 8'h00);
      ret[i] = p0;
      if (i == 5) check(16'(stack_full_out), 16'h0001);
    end
    sync;
    check(16'(instr_out), 16'(rw(11'h2C0)));
    ack_seen = '0;
    irq_v = 3'b100;
    go(PSQ_OP_NONE);
    go(PSQ_OP_NONE);
    check(16'(ack_seen), 16'h0000);
    for (int j = 6; j > 0; j--) begin
      go(j[0] ? PSQ_OP_RET : PSQ_OP_RETURN_ENABLE_INTERRUPTS);
      sync;
      check(16'(instr_out), 16'(rw(ret[j])));
      if (j == 6) begin
        check(16'(stack_full_out), 16'h0000);
        go(PSQ_OP_NONE);
        irq_v = '0;
        pi = p0;
        sync;
        check(16'(ack_seen), 16'h0004);
        go(PSQ_OP_RETURN_ENABLE_INTERRUPTS);
        sync;
        check(16'(instr_out), 16'(rw(pi)));
      end
    end
    wrap_up();
  end
endmodule
